// *** hw/csrl_pkg.sv ***
package csrl_pkg;
  // ---------------------------------------------------------------
  // Card states and codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CSRL_IDLE, CSRL_READY, CSRL_IDENT, CSRL_STBY, CSRL_TRAN,
    CSRL_DATA, CSRL_RCV, CSRL_PRG, CSRL_DIS, CSRL_INA
  } csrl_state_t;

  // ---------------------------------------------------------------
  // Response kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CSRL_RSP_NONE, CSRL_RSP_R1, CSRL_RSP_R1B, CSRL_RSP_R2_CID, CSRL_RSP_R2_CSD, CSRL_RSP_R3
  } csrl_rsp_t;

  localparam logic [3:0] CSRL_CODE_IDLE = 4'h0;
  localparam logic [3:0] CSRL_CODE_READY = 4'h1;
  localparam logic [3:0] CSRL_CODE_IDENT = 4'h2;
  localparam logic [3:0] CSRL_CODE_STBY = 4'h3;
  localparam logic [3:0] CSRL_CODE_TRAN = 4'h4;
  localparam logic [3:0] CSRL_CODE_DATA = 4'h5;
  localparam logic [3:0] CSRL_CODE_RCV = 4'h6;
  localparam logic [3:0] CSRL_CODE_PRG = 4'h7;
  localparam logic [3:0] CSRL_CODE_DIS = 4'h8;
  localparam logic [3:0] CSRL_CODE_INA = 4'hF;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int CSRL_SHORT_LEN = 48;
  localparam int CSRL_LONG_LEN = 136;
  localparam int CSRL_CNT_W = 8;
  localparam logic [31:0] CSRL_OCR_VALUE = 32'h80FF8000;
  localparam int CSRL_OCR_BUSY_BIT = 31;
  localparam logic [47:0] CSRL_R3_READY = 48'h3F80FF8000FF;
  localparam logic [47:0] CSRL_R3_BUSY = 48'h3F00FF8000FF;
  localparam logic [5:0] CSRL_R2_RSVD = 6'h3F;
  localparam logic [1:0] CSRL_START_TX = 2'h0;
  localparam logic END_BIT = 1'b1;

  // Status field positions
  localparam int CSRL_ST_STATE_LO = 9;
  localparam int CSRL_ST_STATE_HI = 12;
  localparam int CSRL_ST_ILLEGAL = 22;
  localparam int CSRL_ST_CRC_ERR = 23;
  localparam int CSRL_ST_LOCKED = 25;
  localparam int CSRL_ST_ECC_DIS = 14;
  // Clear-by-read positions (type C)
  localparam logic [31:0] CSRL_CLR_READ_MASK = 32'hFDFFA000 & ~32'h00C00000;
  // Previous-command positions (type B)
  localparam logic [31:0] CSRL_CLR_PREV_MASK = 32'h00C00000;
  // Command indices
  localparam logic [5:0] CSRL_CMD0 = 6'h00;
  localparam logic [5:0] CSRL_CMD1 = 6'h01;
  localparam logic [5:0] CSRL_CMD2 = 6'h02;
  localparam logic [5:0] CSRL_CMD3 = 6'h03;
  localparam logic [5:0] CSRL_CMD4 = 6'h04;
  localparam logic [5:0] CSRL_CMD7 = 6'h07;
  localparam logic [5:0] CSRL_CMD9 = 6'h09;
  localparam logic [5:0] CSRL_CMD10 = 6'h0A;
  localparam logic [5:0] CSRL_CMD11 = 6'h0B;
  localparam logic [5:0] CSRL_CMD12 = 6'h0C;
  localparam logic [5:0] CSRL_CMD13 = 6'h0D;
  localparam logic [5:0] CSRL_CMD15 = 6'h0F;
  localparam logic [5:0] CSRL_CMD16 = 6'h10;
  localparam logic [5:0] CSRL_CMD17 = 6'h11;
  localparam logic [5:0] CSRL_CMD18 = 6'h12;
  localparam logic [5:0] CSRL_CMD20 = 6'h14;
  localparam logic [5:0] CSRL_CMD23 = 6'h17;
  localparam logic [5:0] CSRL_CMD24 = 6'h18;
  localparam logic [5:0] CSRL_CMD25 = 6'h19;
  localparam logic [5:0] CSRL_CMD26 = 6'h1A;
  localparam logic [5:0] CSRL_CMD27 = 6'h1B;
  localparam logic [5:0] CSRL_CMD28 = 6'h1C;
  localparam logic [5:0] CSRL_CMD29 = 6'h1D;
  localparam logic [5:0] CSRL_CMD30 = 6'h1E;
  localparam logic [5:0] CSRL_CMD35 = 6'h23;
  localparam logic [5:0] CSRL_CMD36 = 6'h24;
  localparam logic [5:0] CSRL_CMD38 = 6'h26;
  localparam logic [5:0] CSRL_CMD42 = 6'h2A;
endpackage : csrl_pkg

// *** hw/csrl_shifter.sv ***
`timescale 1ns/1ns
// Serialises a frame MSB first on bus clock falling edges
module csrl_shifter #(
  parameter int W = 136
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_fall,
  input wire logic i_load,
  input wire logic [W-1:0] i_frame,
  input wire logic [7:0] i_len,
  output logic o_bit,
  output logic o_oe,
  output logic o_busy
);
  if (W < 48 || W > 255) begin : g_bad_width
    $error("csrl_shifter width out of range");
  end

  logic [W-1:0] sh_reg;
  logic [7:0] cnt_reg;

  assign o_busy = (cnt_reg != 8'h00);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_reg <= '0;
      cnt_reg <= 8'h00;
      o_bit <= 1'b1;
      o_oe <= 1'b0;
    end else if (i_load) begin
      sh_reg <= i_frame;
      cnt_reg <= i_len;
    end else if (i_fall) begin
      if (cnt_reg != 8'h00) begin
        o_bit <= sh_reg[W-1];
        o_oe <= 1'b1;
        sh_reg <= {sh_reg[W-2:0], 1'b1};
        cnt_reg <= cnt_reg - 8'h01;
      end else begin
        o_oe <= 1'b0;
        o_bit <= 1'b1;
      end
    end
  end
endmodule : csrl_shifter

// *** hw/csrl_card.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Unlisted command: no state change, no response
// - CMD2 in ready: win goes ident, lose stays
// - Addressed CMD7: stby to tran, dis to prg
// - Other-address CMD7: tran/data to stby, prg to dis
// - Responses serial on command line, MSB first
// - R1 frame: 0,0,index,status,crc,1
// - R1b is R1 plus optional data busy
// - R2 frame: 0,0,reserved,register 127..1,1
// - CID for CMD2/CMD10, CSD for CMD9
// - R3 frame: 0,0,reserved,OCR,reserved,1
// - Fixed OCR value, busy bit 31 cleared while i_pwr_busy
// - R3 frame constants for ready and busy
// - Local status register copied into R1
// - Response-detected bits set in status; erring command is not answered
// - Execution bits set while command runs
// - Previous-command bits cleared two good commands later
// - State bits track; clear-by-read cleared after report
// - State code in status bits 12 to 9
module csrl_card
  import csrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_bus_clk,
  input wire logic i_cmd_valid,
  input wire logic [5:0] i_cmd_index,
  input wire logic i_cmd_crc_ok,
  input wire logic i_addr_match,
  input wire logic i_arb_win,
  input wire logic i_vcc_ok,
  input wire logic i_pwr_busy,
  input wire logic [127:0] i_cid,
  input wire logic [127:0] i_csd,
  input wire logic [6:0] i_crc7,
  input wire logic [31:0] i_exec_set,
  input wire logic i_locked,
  input wire logic i_ecc_dis,
  input wire logic i_prog_busy,
  input wire logic i_prog_done,
  output logic o_cmd_out,
  output logic o_cmd_oe,
  output logic o_dat0_out,
  output logic o_dat0_oe,
  output logic [3:0] o_state_code,
  output logic o_rsp_busy
);
  import csrl_pkg::*;

  // ---------------------------------------------------------------
  // Bus clock edge detect
  // ---------------------------------------------------------------
  logic clk_s1_reg;
  logic clk_s2_reg;
  logic clk_s3_reg;
  wire clk_fall = clk_s3_reg & ~clk_s2_reg;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
    end else begin
      clk_s1_reg <= i_bus_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end

  // ---------------------------------------------------------------
  // Transition decode
  // ---------------------------------------------------------------
  csrl_state_t state_reg;
  csrl_state_t state_next;
  csrl_rsp_t rsp_kind;
  logic legal;

  wire is_rd = (i_cmd_index == CSRL_CMD11) || (i_cmd_index == CSRL_CMD17) ||
               (i_cmd_index == CSRL_CMD18) || (i_cmd_index == CSRL_CMD30);
  wire is_wr = (i_cmd_index == CSRL_CMD20) || (i_cmd_index == CSRL_CMD24) ||
               (i_cmd_index == CSRL_CMD25) || (i_cmd_index == CSRL_CMD26) ||
               (i_cmd_index == CSRL_CMD27) || (i_cmd_index == CSRL_CMD42);
  wire is_pg = (i_cmd_index == CSRL_CMD28) || (i_cmd_index == CSRL_CMD29) ||
               (i_cmd_index == CSRL_CMD38);
  wire is_tr = (i_cmd_index == CSRL_CMD16) || (i_cmd_index == CSRL_CMD23) ||
               (i_cmd_index == CSRL_CMD35) || (i_cmd_index == CSRL_CMD36);

  always_comb begin
    state_next = state_reg;
    rsp_kind = CSRL_RSP_NONE;
    legal = 1'b0;
    if (i_cmd_index == CSRL_CMD0) begin
      if (state_reg != CSRL_INA) begin
        state_next = CSRL_IDLE;
        legal = 1'b1;
      end
    end else if (i_cmd_index == CSRL_CMD15) begin
      if (state_reg >= CSRL_STBY && state_reg <= CSRL_DIS) begin
        state_next = CSRL_INA;
        legal = 1'b1;
      end
    end else if (i_cmd_index == CSRL_CMD13) begin
      if (state_reg >= CSRL_STBY && state_reg <= CSRL_DIS) begin
        legal = 1'b1;
        rsp_kind = CSRL_RSP_R1;
      end
    end else begin
      case (state_reg)
        CSRL_IDLE: begin
          if (i_cmd_index == CSRL_CMD1) begin
            legal = 1'b1;
            if (!i_vcc_ok) begin
              state_next = CSRL_INA;
            end else if (i_pwr_busy) begin
              state_next = CSRL_IDLE;
              rsp_kind = CSRL_RSP_R3;
            end else begin
              state_next = CSRL_READY;
              rsp_kind = CSRL_RSP_R3;
            end
          end
        end
        CSRL_READY: begin
          if (i_cmd_index == CSRL_CMD2) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R2_CID;
            state_next = i_arb_win ? CSRL_IDENT : CSRL_READY;
          end
        end
        CSRL_IDENT: begin
          if (i_cmd_index == CSRL_CMD3) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R1;
            state_next = CSRL_STBY;
          end
        end
        CSRL_STBY: begin
          if (i_cmd_index == CSRL_CMD4) begin
            legal = 1'b1;
          end else if (i_cmd_index == CSRL_CMD9) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R2_CSD;
          end else if (i_cmd_index == CSRL_CMD10) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R2_CID;
          end else if (i_cmd_index == CSRL_CMD7 && i_addr_match) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R1B;
            state_next = CSRL_TRAN;
          end
        end
        CSRL_TRAN: begin
          legal = 1'b1;
          rsp_kind = CSRL_RSP_R1;
          if (i_cmd_index == CSRL_CMD7 && !i_addr_match) begin
            state_next = CSRL_STBY;
            rsp_kind = CSRL_RSP_NONE;
          end else if (is_rd) begin
            state_next = CSRL_DATA;
          end else if (is_wr) begin
            state_next = CSRL_RCV;
          end else if (is_pg) begin
            state_next = CSRL_PRG;
            rsp_kind = CSRL_RSP_R1B;
          end else if (!is_tr) begin
            legal = 1'b0;
            rsp_kind = CSRL_RSP_NONE;
          end
        end
        CSRL_DATA: begin
          if (i_cmd_index == CSRL_CMD7 && !i_addr_match) begin
            legal = 1'b1;
            state_next = CSRL_STBY;
          end else if (i_cmd_index == CSRL_CMD12) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R1;
            state_next = CSRL_TRAN;
          end
        end
        CSRL_RCV: begin
          if (i_cmd_index == CSRL_CMD12) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R1B;
            state_next = CSRL_PRG;
          end
        end
        CSRL_PRG: begin
          if (i_cmd_index == CSRL_CMD7 && !i_addr_match) begin
            legal = 1'b1;
            state_next = CSRL_DIS;
          end else if (i_cmd_index == CSRL_CMD24 || i_cmd_index == CSRL_CMD25) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R1;
            state_next = CSRL_RCV;
          end
        end
        CSRL_DIS: begin
          if (i_cmd_index == CSRL_CMD7 && i_addr_match) begin
            legal = 1'b1;
            rsp_kind = CSRL_RSP_R1B;
            state_next = CSRL_PRG;
          end
        end
        default: begin
          legal = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State code mapping
  // ---------------------------------------------------------------
  logic [3:0] code_now;
  always_comb begin
    case (state_reg)
      CSRL_IDLE: code_now = CSRL_CODE_IDLE;
      CSRL_READY: code_now = CSRL_CODE_READY;
      CSRL_IDENT: code_now = CSRL_CODE_IDENT;
      CSRL_STBY: code_now = CSRL_CODE_STBY;
      CSRL_TRAN: code_now = CSRL_CODE_TRAN;
      CSRL_DATA: code_now = CSRL_CODE_DATA;
      CSRL_RCV: code_now = CSRL_CODE_RCV;
      CSRL_PRG: code_now = CSRL_CODE_PRG;
      CSRL_DIS: code_now = CSRL_CODE_DIS;
      default: code_now = CSRL_CODE_INA;
    endcase
  end

  // ---------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------
  logic [31:0] status_reg;
  logic [31:0] pend_prev_reg;
  wire crc_bad = i_cmd_valid & ~i_cmd_crc_ok;
  wire cmd_good = i_cmd_valid & i_cmd_crc_ok;
  wire ill_cmd = cmd_good & ~legal & (state_reg != CSRL_INA);
  wire take = cmd_good & legal;
  wire sends_r1 = take & ((rsp_kind == CSRL_RSP_R1) || (rsp_kind == CSRL_RSP_R1B));
  wire [31:0] r_flags = (crc_bad ? (32'h1 << CSRL_ST_CRC_ERR) : 32'h0) |
                        (ill_cmd ? (32'h1 << CSRL_ST_ILLEGAL) : 32'h0);
  // Live view with current state and level bits
  wire [31:0] status_view = (status_reg & ~(32'hF << CSRL_ST_STATE_LO) &
                             ~(32'h1 << CSRL_ST_LOCKED) & ~(32'h1 << CSRL_ST_ECC_DIS)) |
                            ({28'h0, code_now} << CSRL_ST_STATE_LO) |
                            ({31'h0, i_locked} << CSRL_ST_LOCKED) |
                            ({31'h0, i_ecc_dis} << CSRL_ST_ECC_DIS);
  logic [31:0] status_next;
  always_comb begin
    status_next = status_reg | i_exec_set;
    if (cmd_good) begin
      status_next = status_next & ~pend_prev_reg;
    end
    if (sends_r1) begin
      status_next = status_next & ~(status_view & CSRL_CLR_READ_MASK) | i_exec_set;
    end
    status_next = status_next | r_flags;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_reg <= 32'h0;
      pend_prev_reg <= 32'h0;
      state_reg <= CSRL_IDLE;
      o_state_code <= CSRL_CODE_IDLE;
    end else begin
      status_reg <= status_next;
      if (cmd_good) begin
        pend_prev_reg <= status_reg & CSRL_CLR_PREV_MASK & ~r_flags;
      end
      if (take) begin
        state_reg <= state_next;
      end
      o_state_code <= code_now;
    end
  end

  // ---------------------------------------------------------------
  // Frame building
  // ---------------------------------------------------------------
  wire [31:0] ocr_word = CSRL_OCR_VALUE & ~({31'h0, i_pwr_busy} << CSRL_OCR_BUSY_BIT);
  wire [47:0] r1_frame = {CSRL_START_TX, i_cmd_index, status_view | r_flags,
                          i_crc7, END_BIT};
  wire [47:0] r3_frame = {CSRL_START_TX, CSRL_R2_RSVD, ocr_word, 7'h7F, END_BIT};
  wire [127:0] reg_sel = (rsp_kind == CSRL_RSP_R2_CSD) ? i_csd : i_cid;
  wire [135:0] r2_frame = {CSRL_START_TX, CSRL_R2_RSVD, reg_sel[127:1], END_BIT};
  wire is_long = (rsp_kind == CSRL_RSP_R2_CID) || (rsp_kind == CSRL_RSP_R2_CSD);
  wire [135:0] frame_sel = is_long ? r2_frame :
                           (rsp_kind == CSRL_RSP_R3) ? {r3_frame, 88'h0} : {r1_frame, 88'h0};
  wire [7:0] len_sel = is_long ? 8'(CSRL_LONG_LEN) : 8'(CSRL_SHORT_LEN);
  wire load = take & (rsp_kind != CSRL_RSP_NONE);
  logic shift_busy;

  csrl_shifter #(
    .W(CSRL_LONG_LEN)
  ) u_shifter (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_fall(clk_fall),
    .i_load(load),
    .i_frame(frame_sel),
    .i_len(len_sel),
    .o_bit(o_cmd_out),
    .o_oe(o_cmd_oe),
    .o_busy(shift_busy)
  );

  // ---------------------------------------------------------------
  // Busy on data line after R1b
  // ---------------------------------------------------------------
  logic r1b_pend_reg;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r1b_pend_reg <= 1'b0;
      o_dat0_out <= 1'b1;
      o_dat0_oe <= 1'b0;
      o_rsp_busy <= 1'b0;
    end else begin
      o_rsp_busy <= shift_busy | load;
      if (load && rsp_kind == CSRL_RSP_R1B) begin
        r1b_pend_reg <= i_prog_busy;
      end else if (i_prog_done) begin
        r1b_pend_reg <= 1'b0;
      end
      if (clk_fall) begin
        o_dat0_oe <= r1b_pend_reg & ~shift_busy;
        o_dat0_out <= 1'b0;
      end
    end
  end

  a_ignore_no_rsp: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cmd_good && !legal) |=> (state_reg == $past(state_reg)) && !o_rsp_busy)
    else $error("ignored command changed state or answered");
  a_cmd2_win: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cmd_good && state_reg == CSRL_READY && i_cmd_index == CSRL_CMD2 && i_arb_win)
    |=> state_reg == CSRL_IDENT)
    else $error("CMD2 win did not reach ident");
  a_select_tran: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cmd_good && state_reg == CSRL_STBY && i_cmd_index == CSRL_CMD7 && i_addr_match)
    |=> state_reg == CSRL_TRAN)
    else $error("select did not reach tran");
  a_deselect_dis: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cmd_good && state_reg == CSRL_PRG && i_cmd_index == CSRL_CMD7 && !i_addr_match)
    |=> state_reg == CSRL_DIS)
    else $error("deselect in prg did not reach dis");
  a_r3_ready_val: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !i_pwr_busy |-> r3_frame == CSRL_R3_READY)
    else $error("R3 ready frame wrong");
  a_state_code: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ##1 o_state_code == $past(code_now))
    else $error("state code lags");
  a_cmd0_idle: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cmd_good && i_cmd_index == CSRL_CMD0 && state_reg != CSRL_INA)
    |=> state_reg == CSRL_IDLE)
    else $error("CMD0 did not reach idle");
  a_crc_flag: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    crc_bad |=> status_reg[CSRL_ST_CRC_ERR])
    else $error("CRC error flag not set");
  a_rsp_len: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (load && !is_long) |=> o_rsp_busy [*3])
    else $error("response start lost");
endmodule : csrl_card

// *** dv/csrl_host_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Host side: bus clock and response capture
// ----------------------------------------
module csrl_host_model (
  input wire logic i_start,
  input wire logic [7:0] i_periods,
  input wire logic i_cmd_out,
  input wire logic i_cmd_oe,
  output logic o_bus_clk,
  output logic [135:0] o_frame,
  output logic [7:0] o_nbits,
  output logic o_done
);
  logic cmd_line;
  // Pulled-up command line
  assign cmd_line = i_cmd_oe ? i_cmd_out : 1'h1;
  initial begin
    o_bus_clk = 1'h1;
    o_done = 1'h1;
    o_frame = '0;
    o_nbits = '0;
  end
  // Clock only in a frame window, sample on rise, MSB first
  always @(posedge i_start) begin
    o_done = 1'h0;
    o_nbits = '0;
    repeat (i_periods) begin
      #80 o_bus_clk = 1'h0;
      #80 o_bus_clk = 1'h1;
      if (i_cmd_oe === 1'h1) begin
        o_frame = {o_frame[134:0], cmd_line};
        o_nbits = o_nbits + 8'h01;
      end
    end
    #80 o_done = 1'h1;
  end
endmodule : csrl_host_model

// *** dv/testbench.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Signals and helpers
// ----------------------------------------
module testbench;
  import csrl_pkg::*;
  logic i_mclk, i_arst_n, i_bus_clk, i_cmd_valid, i_cmd_crc_ok, i_addr_match, i_arb_win;
  logic i_vcc_ok, i_pwr_busy, i_locked, i_ecc_dis, i_prog_busy, i_prog_done, start, hdone;
  logic [5:0] i_cmd_index;
  logic [127:0] i_cid, i_csd;
  logic [6:0] i_crc7;
  logic [31:0] i_exec_set;
  logic o_cmd_out, o_cmd_oe, o_dat0_out, o_dat0_oe, o_rsp_busy;
  logic [3:0] o_state_code;
  logic [7:0] periods, nbits;
  logic [135:0] frame;
  int bad_count, n_tests, cyc;
  logic [5:0] rd [4] = '{CSRL_CMD11, CSRL_CMD17, CSRL_CMD18, CSRL_CMD30};
  logic [5:0] wr [7] = '{CSRL_CMD20, CSRL_CMD26, CSRL_CMD27, CSRL_CMD42, CSRL_CMD28,
    CSRL_CMD29, CSRL_CMD38};
  logic [3:0] wc [7] = '{CSRL_CODE_RCV, CSRL_CODE_RCV, CSRL_CODE_RCV, CSRL_CODE_RCV,
    CSRL_CODE_PRG, CSRL_CODE_PRG, CSRL_CODE_PRG};

  csrl_card i_dut (.i_mclk, .i_arst_n, .i_bus_clk, .i_cmd_valid, .i_cmd_index, .i_cmd_crc_ok,
    .i_addr_match, .i_arb_win, .i_vcc_ok, .i_pwr_busy, .i_cid, .i_csd, .i_crc7, .i_exec_set,
    .i_locked, .i_ecc_dis, .i_prog_busy, .i_prog_done, .o_cmd_out, .o_cmd_oe, .o_dat0_out,
    .o_dat0_oe, .o_state_code, .o_rsp_busy);
  csrl_host_model i_host (.i_start(start), .i_periods(periods), .i_cmd_out(o_cmd_out),
    .i_cmd_oe(o_cmd_oe), .o_bus_clk(i_bus_clk), .o_frame(frame), .o_nbits(nbits),
    .o_done(hdone));

  initial begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Hang guard
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [135:0] seen, input logic [135:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [47:0] r1(logic [5:0] x, logic [31:0] s);
    return {CSRL_START_TX, x, s, i_crc7, END_BIT};
  endfunction : r1

  function automatic logic [31:0] st(logic [3:0] code);
    return {6'h00, i_locked, 10'h000, i_ecc_dis, 1'h0, code, 9'h000};
  endfunction : st

  // Command pulse, then a host window sized to the expected answer
  task automatic cmd(input logic [5:0] x, input logic ok, input logic a);
    @(posedge i_mclk);
    i_cmd_valid <= 1'h1;
    i_cmd_index <= x;
    i_cmd_crc_ok <= ok;
    i_addr_match <= a;
    i_crc7 <= 7'($urandom);
    i_cid <= {$urandom, $urandom, $urandom, $urandom};
    i_csd <= {$urandom, $urandom, $urandom, $urandom};
    @(posedge i_mclk);
    i_cmd_valid <= 1'h0;
    periods <= (x == CSRL_CMD2 || x == CSRL_CMD9 || x == CSRL_CMD10) ? 8'h8C :
      (x == CSRL_CMD0 || x == CSRL_CMD4 || x == CSRL_CMD15 || (x == CSRL_CMD7 && !a)) ?
      8'h06 : 8'h34;
    start <= 1'h1;
    @(posedge i_mclk);
    start <= 1'h0;
    for (int k = 0; k < 3000 && hdone !== 1'h1; k++) @(posedge i_mclk);
    chk("host window", hdone, 1'h1);
  endtask : cmd

  task automatic step(input logic [5:0] x, input logic a, input logic [3:0] code);
    cmd(x, 1'h1, a);
    chk("state", o_state_code, code);
    chk("rsp idle", o_rsp_busy, 1'h0);
  endtask : step

  task automatic to_tran();
    step(CSRL_CMD0, 1'h0, CSRL_CODE_IDLE);
    step(CSRL_CMD1, 1'h0, CSRL_CODE_READY);
    step(CSRL_CMD2, 1'h0, CSRL_CODE_IDENT);
    step(CSRL_CMD3, 1'h0, CSRL_CODE_STBY);
    step(CSRL_CMD7, 1'h1, CSRL_CODE_TRAN);
  endtask : to_tran

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(65));
    i_arst_n = 1'h0;
    i_vcc_ok = 1'h1;
    {i_cmd_valid, i_cmd_crc_ok, i_addr_match, i_arb_win, i_pwr_busy, i_locked} = '0;
    {i_ecc_dis, i_prog_busy, i_prog_done, start} = '0;
    {i_cmd_index, i_cid, i_csd, i_crc7, i_exec_set, periods} = '0;
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'h1;
    @(posedge i_mclk);
    chk("reset state", o_state_code, CSRL_CODE_IDLE);
    chk("reset oe", o_cmd_oe, 1'h0);
    for (int k = 0; k < 4; k++) begin
      cmd(6'(2 + $urandom_range(61)), 1'h1, 1'h0);
      chk("silent bits", nbits, 8'h00);
      chk("silent state", o_state_code, CSRL_CODE_IDLE);
    end
    $display("test ignored done");
    i_pwr_busy <= 1'h1;
    cmd(CSRL_CMD1, 1'h1, 1'h0);
    chk("r3 busy", frame[47:0], {8'h3F, 32'h00FF8000, 8'hFF});
    chk("busy state", o_state_code, CSRL_CODE_IDLE);
    i_pwr_busy <= 1'h0;
    cmd(CSRL_CMD1, 1'h1, 1'h0);
    chk("r3 ready", frame[47:0], {8'h3F, 32'h80FF8000, 8'hFF});
    chk("r3 bits", nbits, 8'h30);
    step(CSRL_CMD2, 1'h0, CSRL_CODE_READY);
    i_arb_win <= 1'h1;
    step(CSRL_CMD2, 1'h0, CSRL_CODE_IDENT);
    chk("r2 cid", frame, {CSRL_START_TX, CSRL_R2_RSVD, i_cid[127:1], END_BIT});
    chk("r2 bits", nbits, 8'h88);
    step(CSRL_CMD3, 1'h0, CSRL_CODE_STBY);
    chk("r1 head", frame[47:40], {CSRL_START_TX, CSRL_CMD3});
    chk("r1 tail", frame[7:0], {i_crc7, END_BIT});
    chk("r1 bits", nbits, 8'h30);
    step(CSRL_CMD9, 1'h0, CSRL_CODE_STBY);
    chk("r2 csd", frame, {CSRL_START_TX, CSRL_R2_RSVD, i_csd[127:1], END_BIT});
    step(CSRL_CMD10, 1'h0, CSRL_CODE_STBY);
    chk("r2 cid10", frame, {CSRL_START_TX, CSRL_R2_RSVD, i_cid[127:1], END_BIT});
    $display("test identify done");
    step(CSRL_CMD4, 1'h0, CSRL_CODE_STBY);
    step(CSRL_CMD7, 1'h1, CSRL_CODE_TRAN);
    step(CSRL_CMD7, 1'h0, CSRL_CODE_STBY);
    step(CSRL_CMD7, 1'h1, CSRL_CODE_TRAN);
    step(CSRL_CMD17, 1'h0, CSRL_CODE_DATA);
    step(CSRL_CMD7, 1'h0, CSRL_CODE_STBY);
    step(CSRL_CMD7, 1'h1, CSRL_CODE_TRAN);
    i_locked <= 1'($urandom);
    i_ecc_dis <= 1'($urandom);
    cmd(CSRL_CMD13, 1'h1, 1'h0);
    chk("status", frame[47:0], r1(CSRL_CMD13, st(CSRL_CODE_TRAN)));
    @(posedge i_mclk);
    i_exec_set <= 32'h80000000;
    @(posedge i_mclk);
    i_exec_set <= 32'h00000000;
    cmd(CSRL_CMD13, 1'h1, 1'h0);
    chk("exec set", frame[47:0], r1(CSRL_CMD13, st(CSRL_CODE_TRAN) | 32'h80000000));
    cmd(CSRL_CMD13, 1'h1, 1'h0);
    chk("exec clear", frame[47:0], r1(CSRL_CMD13, st(CSRL_CODE_TRAN)));
    cmd(CSRL_CMD13, 1'h0, 1'h0);
    chk("crc silent", nbits, 8'h00);
    cmd(CSRL_CMD13, 1'h1, 1'h0);
    chk("crc flag", frame[31], 1'h1);
    cmd(CSRL_CMD13, 1'h1, 1'h0);
    cmd(CSRL_CMD13, 1'h1, 1'h0);
    chk("crc cleared", frame[31], 1'h0);
    $display("test status done");
    foreach (rd[k]) begin
      step(rd[k], 1'h0, CSRL_CODE_DATA);
      step(CSRL_CMD12, 1'h0, CSRL_CODE_TRAN);
    end
    foreach (wr[k]) begin
      i_prog_busy <= (wr[k] == CSRL_CMD38);
      step(wr[k], 1'h0, wc[k]);
      if (k < 6) to_tran();
    end
    chk("dat0 busy", {o_dat0_oe, o_dat0_out}, 2'h2);
    i_prog_done <= 1'h1;
    i_prog_busy <= 1'h0;
    periods <= 8'h04;
    start <= 1'h1;
    @(posedge i_mclk);
    i_prog_done <= 1'h0;
    start <= 1'h0;
    @(posedge i_mclk);
    for (int k = 0; k < 3000 && hdone !== 1'h1; k++) @(posedge i_mclk);
    chk("dat0 free", o_dat0_oe, 1'h0);
    $display("test transfer done");
    step(CSRL_CMD24, 1'h0, CSRL_CODE_RCV);
    step(CSRL_CMD12, 1'h0, CSRL_CODE_PRG);
    step(CSRL_CMD25, 1'h0, CSRL_CODE_RCV);
    step(CSRL_CMD12, 1'h0, CSRL_CODE_PRG);
    step(CSRL_CMD7, 1'h0, CSRL_CODE_DIS);
    step(CSRL_CMD7, 1'h1, CSRL_CODE_PRG);
    step(CSRL_CMD7, 1'h0, CSRL_CODE_DIS);
    step(CSRL_CMD15, 1'h0, CSRL_CODE_INA);
    step(CSRL_CMD0, 1'h0, CSRL_CODE_INA);
    $display("test program done");
    i_arst_n <= 1'h0;
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'h1;
    i_vcc_ok <= 1'h0;
    @(posedge i_mclk);
    chk("rerun state", o_state_code, CSRL_CODE_IDLE);
    step(CSRL_CMD1, 1'h0, CSRL_CODE_INA);
    chk("vcc silent", nbits, 8'h00);
    $display("test reset done");
    complete_run();
  end
endmodule : testbench
